// ===== design/dpbr_pkg.sv
// package: shared constants and types for the dual-port burst ram port
package dpbr_pkg;
  localparam int DPBR_ADDR_W = 17;
  localparam int DPBR_DATA_W = 36;
  localparam int DPBR_LANES = 4;
  localparam int DPBR_LANE_W = 9;
  localparam int DPBR_DEPTH = 1024;
  localparam int DPBR_MEM_AW = 10;
  localparam logic [DPBR_ADDR_W-1:0] DPBR_MASK_RESET = 17'h1FFFF;
  localparam logic [DPBR_ADDR_W-1:0] DPBR_ADDR_ZERO = 17'h00000;
  localparam logic [DPBR_DATA_W-1:0] DPBR_DATA_ZERO = 36'h000000000;
  localparam int DPBR_CLK_MHZ = 50;
  // skew figure in tenths of ns, and its cycle count at the clock rate
  localparam int DPBR_SKEW_MIN_TENTH_NS = 52;
  localparam int DPBR_SKEW_CYCLES = (DPBR_SKEW_MIN_TENTH_NS * DPBR_CLK_MHZ + 9999) / 10000;
  typedef enum logic [1:0] {DPBR_OP_IDLE, DPBR_OP_READ, DPBR_OP_WRITE, DPBR_OP_NOP} dpbr_op_type;
endpackage

// ===== design/dpbr_if.sv
// interface: one port's pins between host and ram port
`timescale 1ns/10ps
interface dpbr_if;
  import dpbr_pkg::*;
  logic chip_select_low_active;
  logic chip_select_high_active;
  logic read_write;
  logic output_enable_n;
  logic address_strobe_n;
  logic counter_enable_n;
  logic counter_clear_n;
  logic counter_or_mask_select;
  logic master_reset_n;
  logic [DPBR_LANES-1:0] byte_lane_enables;
  logic [DPBR_ADDR_W-1:0] addr_host_out;
  logic addr_host_oe;
  logic [DPBR_ADDR_W-1:0] addr_dev_out;
  logic addr_dev_oe;
  logic [DPBR_DATA_W-1:0] data_host_out;
  logic data_host_oe;
  logic [DPBR_DATA_W-1:0] data_dev_out;
  logic data_dev_oe;
  logic counter_wrap_irq_n;
  modport device (
    input chip_select_low_active, chip_select_high_active, read_write, output_enable_n,
    input address_strobe_n, counter_enable_n, counter_clear_n, counter_or_mask_select,
    input master_reset_n, byte_lane_enables, addr_host_out, addr_host_oe, data_host_out, data_host_oe,
    output addr_dev_out, addr_dev_oe, data_dev_out, data_dev_oe, counter_wrap_irq_n
  );
  modport host (
    output chip_select_low_active, chip_select_high_active, read_write, output_enable_n,
    output address_strobe_n, counter_enable_n, counter_clear_n, counter_or_mask_select,
    output master_reset_n, byte_lane_enables, addr_host_out, addr_host_oe, data_host_out, data_host_oe,
    input addr_dev_out, addr_dev_oe, data_dev_out, data_dev_oe, counter_wrap_irq_n
  );
endinterface

// ===== design/dpbr_port.sv
// device end: one synchronous port of the burst ram with its own memory array
//
// Functional notes
// - output enable and master reset asynchronous, rest sampled on clock
// - deselect floats data from next edge
// - strobe and enable low load address
// - outputs follow previous cycle controls
// - host rewrites address after turnaround nop
// - first write with output enable low is nop
// - counter clear allows same-cycle access
// - host releases address bus before readback
// - host drives address only after release
// - readback shows counter or mask by select
// - cross-port write seen one or two cycles later
// - hosts keep port clock skew
// - wrap irq low at unmasked maximum
// - wrap continues from loaded address
// - master reset clears wrap irq asynchronously
// - master reset forces outputs inactive asynchronously
// - chip enable change has one cycle latency
`timescale 1ns/10ps
module dpbr_port (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // pins
  dpbr_if.device pins,
  // other port's write, for collision forwarding
  input wire logic peer_wr,
  input wire logic [dpbr_pkg::DPBR_ADDR_W-1:0] peer_wr_addr,
  input wire logic [dpbr_pkg::DPBR_DATA_W-1:0] peer_wr_data,
  input wire logic [dpbr_pkg::DPBR_LANES-1:0] peer_wr_lanes,
  input wire logic skew_ok,
  // this port's write, towards the other port
  output logic own_wr,
  output logic [dpbr_pkg::DPBR_ADDR_W-1:0] own_wr_addr,
  output logic [dpbr_pkg::DPBR_DATA_W-1:0] own_wr_data,
  output logic [dpbr_pkg::DPBR_LANES-1:0] own_wr_lanes
);
  import dpbr_pkg::*;

  typedef struct packed {
    logic [DPBR_ADDR_W-1:0] counter;
    logic [DPBR_ADDR_W-1:0] loaded;
    logic [DPBR_ADDR_W-1:0] mask;
    logic irq_n;
    logic selected;
    logic prev_write;
    logic drive_data;
    logic [DPBR_DATA_W-1:0] dout;
    logic readback;
    logic [DPBR_ADDR_W-1:0] rb_val;
    logic wr;
    logic [DPBR_ADDR_W-1:0] wr_addr;
    logic [DPBR_DATA_W-1:0] wr_data;
    logic [DPBR_LANES-1:0] wr_lanes;
    logic late_pend;
    logic [DPBR_ADDR_W-1:0] late_addr;
  } dpbr_state_type;

  dpbr_state_type st;
  dpbr_state_type next_st;
  logic [DPBR_DATA_W-1:0] mem [DPBR_DEPTH];

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [DPBR_MEM_AW-1:0] dpbr_row(input logic [DPBR_ADDR_W-1:0] a);
    return a[DPBR_MEM_AW-1:0];
  endfunction

  function automatic logic [DPBR_DATA_W-1:0] dpbr_merge(input logic [DPBR_DATA_W-1:0] old_d,
      input logic [DPBR_DATA_W-1:0] new_d, input logic [DPBR_LANES-1:0] lanes);
    logic [DPBR_DATA_W-1:0] r;
    r = old_d;
    for (int i = 0; i < DPBR_LANES; i++) begin
      if (lanes[i]) begin
        r[i*DPBR_LANE_W +: DPBR_LANE_W] = new_d[i*DPBR_LANE_W +: DPBR_LANE_W];
      end
    end
    return r;
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic sel;
  logic [DPBR_ADDR_W-1:0] ext_addr;
  logic [DPBR_ADDR_W-1:0] acc_addr;
  logic [DPBR_ADDR_W-1:0] incd;
  logic rb_req;
  logic peer_hit;

  always_comb begin
    next_st = st;
    sel = !pins.chip_select_low_active && pins.chip_select_high_active;
    ext_addr = pins.addr_host_out;
    rb_req = sel && !pins.address_strobe_n && pins.counter_enable_n && pins.read_write && pins.counter_clear_n;
    acc_addr = st.counter;
    incd = st.counter;
    next_st.wr = 1'b0;
    if (!pins.counter_clear_n) begin
      // unmasked bits go to zero; access proceeds this cycle
      next_st.counter = st.counter & ~st.mask;
      next_st.loaded = st.counter & ~st.mask;
      next_st.irq_n = 1'b1;
      acc_addr = st.counter & ~st.mask;
    end else if (!pins.address_strobe_n && !pins.counter_enable_n) begin
      if (pins.counter_or_mask_select) begin
        next_st.counter = ext_addr;
        next_st.loaded = ext_addr;
        next_st.irq_n = 1'b1;
        acc_addr = ext_addr;
      end else begin
        next_st.mask = ext_addr;
      end
    end else if (pins.address_strobe_n && !pins.counter_enable_n) begin
      incd = (st.counter & ~st.mask) | ((st.counter + 17'h00001) & st.mask);
      if ((st.counter & st.mask) == st.mask) begin
        incd = st.loaded;
      end else if ((incd & st.mask) == st.mask) begin
        next_st.irq_n = 1'b0;
      end
      next_st.counter = incd;
      acc_addr = incd;
    end
    // readback drives the address pins from the next edge
    next_st.readback = rb_req;
    next_st.rb_val = pins.counter_or_mask_select ? st.counter : st.mask;
    // deselect and select both land one edge later
    next_st.selected = sel;
    next_st.prev_write = sel && !pins.read_write;
    next_st.drive_data = 1'b0;
    if (sel && !pins.read_write && (st.prev_write || pins.output_enable_n)) begin
      // a write when the bus was driven by us needs one nop cycle first
      next_st.wr = 1'b1;
      next_st.wr_addr = acc_addr;
      next_st.wr_data = pins.data_host_out;
      next_st.wr_lanes = ~pins.byte_lane_enables;
    end else if (sel && pins.read_write && !rb_req) begin
      next_st.drive_data = 1'b1;
      next_st.dout = mem[dpbr_row(acc_addr)];
    end
    // collision with the other port's write in flight
    peer_hit = peer_wr && dpbr_row(peer_wr_addr) == dpbr_row(acc_addr);
    next_st.late_pend = 1'b0;
    next_st.late_addr = acc_addr;
    if (peer_hit && next_st.drive_data && !skew_ok) begin
      next_st.late_pend = 1'b1;
    end
    // only a read that stays selected on the late word may refresh it; a deselect floats the bus
    if (st.late_pend && st.drive_data && st.selected && next_st.drive_data &&
        dpbr_row(acc_addr) == dpbr_row(st.late_addr)) begin
      next_st.dout = mem[dpbr_row(st.late_addr)];
      next_st.drive_data = 1'b1;
    end
    if (peer_hit && next_st.drive_data && skew_ok) begin
      next_st.dout = dpbr_merge(mem[dpbr_row(acc_addr)], peer_wr_data, peer_wr_lanes);
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge pins.master_reset_n) begin
    if (!pins.master_reset_n) begin
      st <= '0;
      st.irq_n <= 1'b1;
      st.mask <= DPBR_MASK_RESET;
    end else if (!rst_b) begin
      st <= '0;
      st.irq_n <= 1'b1;
      st.mask <= DPBR_MASK_RESET;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // array has no reset; the peer's writes land here too so one array models the shared cell
  always_ff @(posedge clk) begin
    if (clk_en && pins.master_reset_n && rst_b) begin
      if (st.wr) begin
        mem[dpbr_row(st.wr_addr)] <= dpbr_merge(mem[dpbr_row(st.wr_addr)], st.wr_data, st.wr_lanes);
      end
      if (peer_wr) begin
        mem[dpbr_row(peer_wr_addr)] <= dpbr_merge(mem[dpbr_row(peer_wr_addr)], peer_wr_data, peer_wr_lanes);
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // output enable gates asynchronously
  assign pins.data_dev_out = st.dout;
  assign pins.data_dev_oe = st.drive_data && !pins.output_enable_n;
  assign pins.addr_dev_out = st.rb_val;
  assign pins.addr_dev_oe = st.readback;
  assign pins.counter_wrap_irq_n = st.irq_n;
  assign own_wr = st.wr;
  assign own_wr_addr = st.wr_addr;
  assign own_wr_data = st.wr_data;
  assign own_wr_lanes = st.wr_lanes;
endmodule

// ===== design/dpbr_host.sv
// host end: drives one port from a simple user command
`timescale 1ns/10ps
module dpbr_host (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // user side
  input wire logic cmd_valid,
  input wire dpbr_pkg::dpbr_op_type cmd_op,
  input wire logic [dpbr_pkg::DPBR_ADDR_W-1:0] cmd_addr,
  input wire logic [dpbr_pkg::DPBR_DATA_W-1:0] cmd_data,
  input wire logic cmd_readback,
  input wire logic cmd_rb_mask,
  input wire logic reset_req,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [dpbr_pkg::DPBR_DATA_W-1:0] rsp_data,
  output logic [dpbr_pkg::DPBR_ADDR_W-1:0] rsp_addr,
  output logic wrap_seen,
  // pins
  dpbr_if.host pins
);
  import dpbr_pkg::*;

  typedef enum logic [2:0] {DPBR_H_IDLE, DPBR_H_RD, DPBR_H_RD2, DPBR_H_RB, DPBR_H_RB2, DPBR_H_REL} dpbr_hstate_type;

  typedef struct packed {
    dpbr_hstate_type fsm;
    logic cs;
    logic rw;
    logic ads_n;
    logic cnt_n;
    logic cm;
    logic [DPBR_ADDR_W-1:0] addr;
    logic addr_oe;
    logic [DPBR_DATA_W-1:0] data;
    logic data_oe;
    logic master_reset_n_n;
    logic rdy;
    logic rv;
    logic [DPBR_DATA_W-1:0] rd;
    logic [DPBR_ADDR_W-1:0] ra;
    logic wrap;
    logic [2:0] irq_sync;
    logic adv;
  } dpbr_hst_type;

  dpbr_hst_type st;
  dpbr_hst_type next_st;

  always_comb begin
    next_st = st;
    next_st.rv = 1'b0;
    next_st.ads_n = 1'b0;
    next_st.cnt_n = 1'b0;
    next_st.cm = 1'b1;
    next_st.rw = 1'b1;
    next_st.data_oe = 1'b0;
    next_st.master_reset_n_n = !reset_req;
    next_st.irq_sync = {st.irq_sync[1:0], pins.counter_wrap_irq_n};
    next_st.wrap = st.irq_sync[1] == st.irq_sync[2] && !st.irq_sync[2];
    unique case (st.fsm)
      DPBR_H_IDLE: begin
        next_st.cs = 1'b0;
        next_st.rdy = 1'b1;
        next_st.addr_oe = 1'b1;
        next_st.adv = 1'b0;
        if (cmd_valid && st.rdy) begin
          next_st.rdy = 1'b0;
          next_st.cs = 1'b1;
          next_st.addr = cmd_addr;
          if (cmd_readback) begin
            // release address bus the same edge readback is requested
            next_st.cnt_n = 1'b1;
            next_st.cm = !cmd_rb_mask;
            next_st.addr_oe = 1'b0;
            next_st.fsm = DPBR_H_RB;
          end else if (cmd_op == DPBR_OP_WRITE) begin
            // output enable is high outside reads, so no turnaround nop is needed
            next_st.rw = 1'b0;
            next_st.data = cmd_data;
            next_st.data_oe = 1'b1;
            next_st.fsm = DPBR_H_REL;
          end else begin
            if (cmd_op == DPBR_OP_NOP) begin
              // step the burst counter instead of loading it
              next_st.ads_n = 1'b1;
              next_st.adv = 1'b1;
            end
            next_st.fsm = DPBR_H_RD;
          end
        end
      end
      DPBR_H_RD: begin
        next_st.cs = 1'b0;
        next_st.fsm = DPBR_H_RD2;
      end
      DPBR_H_RD2: begin
        next_st.rv = 1'b1;
        next_st.rd = pins.data_dev_out;
        next_st.fsm = DPBR_H_REL;
      end
      DPBR_H_RB: begin
        next_st.cs = 1'b0;
        next_st.fsm = DPBR_H_RB2;
      end
      DPBR_H_RB2: begin
        next_st.rv = 1'b1;
        next_st.ra = pins.addr_dev_out;
        next_st.fsm = DPBR_H_REL;
      end
      DPBR_H_REL: begin
        next_st.cs = 1'b0;
        next_st.fsm = DPBR_H_IDLE;
      end
    endcase
    // hold the counter after a step, so the wrap flag lasts long enough to pass the synchroniser
    if (st.adv && st.fsm != DPBR_H_IDLE) begin
      next_st.ads_n = 1'b1;
      next_st.cnt_n = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st <= '0;
      st.fsm <= DPBR_H_IDLE;
      st.master_reset_n_n <= 1'b1;
      st.rw <= 1'b1;
      st.ads_n <= 1'b1;
      st.cnt_n <= 1'b1;
      st.cm <= 1'b1;
      st.irq_sync <= 3'h7;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign pins.chip_select_low_active = !st.cs;
  assign pins.chip_select_high_active = st.cs;
  assign pins.read_write = st.rw;
  // output enable held inactive off reads keeps writes free of turnaround
  assign pins.output_enable_n = !(st.fsm == DPBR_H_RD || st.fsm == DPBR_H_RD2);
  assign pins.address_strobe_n = st.ads_n;
  assign pins.counter_enable_n = st.cnt_n;
  assign pins.counter_clear_n = 1'b1;
  assign pins.counter_or_mask_select = st.cm;
  assign pins.master_reset_n = st.master_reset_n_n;
  assign pins.byte_lane_enables = 4'h0;
  assign pins.addr_host_out = st.addr;
  assign pins.addr_host_oe = st.addr_oe;
  assign pins.data_host_out = st.data;
  assign pins.data_host_oe = st.data_oe;
  assign cmd_ready = st.rdy;
  assign rsp_valid = st.rv;
  assign rsp_data = st.rd;
  assign rsp_addr = st.ra;
  assign wrap_seen = st.wrap;
endmodule

// ===== tb/dpbr_port_properties.sv
// checker: pin properties of one host and ram port pair
`timescale 1ns/10ps
module dpbr_port_properties (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // host driven
  input wire logic chip_select_low_active,
  input wire logic chip_select_high_active,
  input wire logic read_write,
  input wire logic output_enable_n,
  input wire logic address_strobe_n,
  input wire logic counter_enable_n,
  input wire logic counter_clear_n,
  input wire logic counter_or_mask_select,
  input wire logic master_reset_n,
  input wire logic [dpbr_pkg::DPBR_ADDR_W-1:0] addr_host_out,
  input wire logic addr_host_oe,
  input wire logic data_host_oe,
  // device driven
  input wire logic [dpbr_pkg::DPBR_ADDR_W-1:0] addr_dev_out,
  input wire logic addr_dev_oe,
  input wire logic data_dev_oe,
  input wire logic counter_wrap_irq_n
);
  import dpbr_pkg::*;
  // ------
  // last counter load
  // ------
  logic sel;
  logic rb;
  logic ld;
  logic ld_ok;
  logic [DPBR_ADDR_W-1:0] ld_addr;
  assign sel = !chip_select_low_active && chip_select_high_active;
  // the counter loads whether or not the port is selected
  assign ld = !address_strobe_n && !counter_enable_n && counter_or_mask_select;
  assign rb = sel && read_write && !address_strobe_n && counter_enable_n && counter_clear_n;
  // any other counter move makes the tracked value stale, so the check goes quiet
  always_ff @(posedge clk) begin
    ld_ok <= rst_b && master_reset_n && counter_clear_n && (ld || (ld_ok && counter_enable_n));
    if (ld) begin
      ld_addr <= addr_host_out;
    end
  end
  // ------
  // properties
  // ------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_oe_async; output_enable_n |-> !data_dev_oe; endproperty
  a_oe_async: assert property (p_oe_async) else $error("data driven while output enable off");
  property p_deselect; !sel |=> !data_dev_oe && !addr_dev_oe; endproperty
  a_deselect: assert property (p_deselect) else $error("outputs on after deselect");
  property p_read_pipe;
    sel && read_write && !address_strobe_n && !counter_enable_n && master_reset_n
      |=> data_dev_oe || output_enable_n || !master_reset_n;
  endproperty
  a_read_pipe: assert property (p_read_pipe) else $error("read data not driven next cycle");
  property p_readback;
    rb && ld_ok && counter_or_mask_select |=> !master_reset_n || (addr_dev_oe && addr_dev_out == ld_addr);
  endproperty
  a_readback: assert property (p_readback) else $error("counter readback wrong");
  property p_no_fight; !(addr_host_oe && addr_dev_oe) && !(data_host_oe && data_dev_oe); endproperty
  a_no_fight: assert property (p_no_fight) else $error("both ends drive one bus");
  property p_mreset; !master_reset_n |-> counter_wrap_irq_n && !data_dev_oe && !addr_dev_oe; endproperty
  a_mreset: assert property (p_mreset) else $error("outputs active in master reset");
  property p_irq_hold;
    !counter_wrap_irq_n && address_strobe_n && counter_clear_n |=> !counter_wrap_irq_n || !master_reset_n;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("wrap flag dropped early");
  property p_irq_cause;
    $fell(counter_wrap_irq_n) |-> $past(counter_enable_n) == 1'b0 && $past(address_strobe_n) == 1'b1;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("wrap flag without increment");
  c_readback: cover property (rb ##1 addr_dev_oe);
  c_read: cover property (data_dev_oe);
  c_mreset: cover property ($fell(master_reset_n));
  c_wrap: cover property ($fell(counter_wrap_irq_n));
endmodule

// ===== tb/dpbr_port_tb.sv
// testbench: two host ends on two cross-linked ram ports
`timescale 1ns/10ps
module dpbr_port_tb;
  import dpbr_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cmd_valid [2];
  dpbr_op_type cmd_op [2];
  logic [DPBR_ADDR_W-1:0] cmd_addr [2];
  logic [DPBR_DATA_W-1:0] cmd_data [2];
  logic cmd_readback [2];
  logic cmd_rb_mask [2];
  logic reset_req [2];
  logic skew_ok [2];
  logic cmd_ready [2];
  logic rsp_valid [2];
  logic [DPBR_DATA_W-1:0] rsp_data [2];
  logic [DPBR_ADDR_W-1:0] rsp_addr [2];
  logic wrap_seen [2];
  logic own_wr [2];
  logic [DPBR_ADDR_W-1:0] own_wr_addr [2];
  logic [DPBR_DATA_W-1:0] own_wr_data [2];
  logic [DPBR_LANES-1:0] own_wr_lanes [2];
  logic [DPBR_DATA_W-1:0] model [DPBR_DEPTH];
  logic [DPBR_DATA_W-1:0] got_d;
  logic [DPBR_ADDR_W-1:0] got_a;
  integer seed = 32'h2941;
  int fails = 0;
  int checked = 0;
  always #10 clk = ~clk;
  // ------
  // two ends per side, writes cross over to the other port
  // ------
  for (genvar s = 0; s < 2; s++) begin : g_side
    dpbr_if pins ();
    dpbr_host i_dpbr_host (.clk(clk), .rst_b(rst_b), .clk_en(1'b1), .cmd_valid(cmd_valid[s]), .cmd_op(cmd_op[s]),
      .cmd_addr(cmd_addr[s]), .cmd_data(cmd_data[s]), .cmd_readback(cmd_readback[s]), .cmd_rb_mask(cmd_rb_mask[s]),
      .reset_req(reset_req[s]), .cmd_ready(cmd_ready[s]), .rsp_valid(rsp_valid[s]), .rsp_data(rsp_data[s]),
      .rsp_addr(rsp_addr[s]), .wrap_seen(wrap_seen[s]), .pins(pins));
    dpbr_port i_dpbr_port (.clk(clk), .rst_b(rst_b), .clk_en(1'b1), .pins(pins), .peer_wr(own_wr[1-s]),
      .peer_wr_addr(own_wr_addr[1-s]), .peer_wr_data(own_wr_data[1-s]), .peer_wr_lanes(own_wr_lanes[1-s]),
      .skew_ok(skew_ok[s]), .own_wr(own_wr[s]), .own_wr_addr(own_wr_addr[s]), .own_wr_data(own_wr_data[s]),
      .own_wr_lanes(own_wr_lanes[s]));
    if (s == 0) begin : g_chk
      dpbr_port_properties i_dpbr_port_properties (.clk(clk), .rst_b(rst_b),
        .chip_select_low_active(pins.chip_select_low_active), .chip_select_high_active(pins.chip_select_high_active),
        .read_write(pins.read_write), .output_enable_n(pins.output_enable_n),
        .address_strobe_n(pins.address_strobe_n), .counter_enable_n(pins.counter_enable_n),
        .counter_clear_n(pins.counter_clear_n), .counter_or_mask_select(pins.counter_or_mask_select),
        .master_reset_n(pins.master_reset_n), .addr_host_out(pins.addr_host_out), .addr_host_oe(pins.addr_host_oe),
        .data_host_oe(pins.data_host_oe), .addr_dev_out(pins.addr_dev_out), .addr_dev_oe(pins.addr_dev_oe),
        .data_dev_oe(pins.data_dev_oe), .counter_wrap_irq_n(pins.counter_wrap_irq_n));
    end
  end
  // ------
  // tasks
  // ------
  function automatic logic [DPBR_DATA_W-1:0] expect_word(input logic [DPBR_ADDR_W-1:0] a);
    return model[a[DPBR_MEM_AW-1:0]];
  endfunction
  // met skew forwards the new word at once, otherwise the reader still sees the old one
  function automatic logic [DPBR_DATA_W-1:0] collide_word(input logic ok, input logic [DPBR_DATA_W-1:0] old_d,
      input logic [DPBR_DATA_W-1:0] new_d);
    return ok ? new_d : old_d;
  endfunction
  task automatic check(input logic [DPBR_DATA_W-1:0] seen, input logic [DPBR_DATA_W-1:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("checked %0d, fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // flags are looked at on falling edges, where registered outputs have settled
  task automatic await(input int s, input bit rsp);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
      if (n > 40) begin
        fails++;
        final_report;
      end
    end while ((rsp ? rsp_valid[s] : cmd_ready[s]) !== 1'b1);
  endtask
  // entered on a rising edge; holds the command until the edge that takes it
  task automatic issue(input int s, input dpbr_op_type op, input logic [DPBR_ADDR_W-1:0] a,
      input logic [DPBR_DATA_W-1:0] d, input logic rb, input logic mk);
    cmd_valid[s] <= 1'b1;
    cmd_op[s] <= op;
    cmd_addr[s] <= a;
    cmd_data[s] <= d;
    cmd_readback[s] <= rb;
    cmd_rb_mask[s] <= mk;
    await(s, 1'b0);
    @(posedge clk);
    cmd_valid[s] <= 1'b0;
    if (op != DPBR_OP_WRITE) begin
      await(s, 1'b1);
      got_d = rsp_data[s];
      got_a = rsp_addr[s];
    end
    @(posedge clk);
  endtask
  // ------
  // sequence
  // ------
  initial begin
    logic [DPBR_ADDR_W-1:0] a;
    logic [DPBR_DATA_W-1:0] d;
    int s;
    for (int k = 0; k < 2; k++) begin
      cmd_valid[k] = 1'b0;
      cmd_op[k] = DPBR_OP_IDLE;
      cmd_addr[k] = DPBR_ADDR_ZERO;
      cmd_data[k] = DPBR_DATA_ZERO;
      cmd_readback[k] = 1'b0;
      cmd_rb_mask[k] = 1'b0;
      reset_req[k] = 1'b0;
      skew_ok[k] = 1'b1;
    end
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    for (int k = 0; k < 2; k++) begin
      issue(k, DPBR_OP_READ, DPBR_ADDR_ZERO, DPBR_DATA_ZERO, 1'b1, 1'b1);
      check(got_a, DPBR_MASK_RESET);
    end
    // first four passes use the extreme addresses and data patterns
    for (int i = 0; i < 40; i++) begin
      s = (i < 4) ? i % 2 : $random(seed) & 1;
      a = (i < 4) ? {DPBR_ADDR_W{i[0]}} : DPBR_ADDR_W'($random(seed));
      d = (i < 4) ? {DPBR_DATA_W{i[1]}} : DPBR_DATA_W'({$random(seed), $random(seed)});
      skew_ok[0] <= 1'($random(seed));
      skew_ok[1] <= 1'($random(seed));
      issue(s, DPBR_OP_WRITE, a, d, 1'b0, 1'b0);
      model[a[DPBR_MEM_AW-1:0]] = d;
      issue(1 - s, DPBR_OP_READ, a, DPBR_DATA_ZERO, 1'b0, 1'b0);
      check(got_d, expect_word(a));
      issue(s, DPBR_OP_READ, a, DPBR_DATA_ZERO, 1'b0, 1'b0);
      check(got_d, expect_word(a));
      issue(s, DPBR_OP_READ, DPBR_ADDR_ZERO, DPBR_DATA_ZERO, 1'b1, 1'b0);
      check(got_a, a);
      // the other port reads the word one cycle after this one starts overwriting it
      await(s, 1'b0);
      await(1 - s, 1'b0);
      @(posedge clk);
      fork
        issue(s, DPBR_OP_WRITE, a, ~d, 1'b0, 1'b0);
        begin
          @(posedge clk);
          issue(1 - s, DPBR_OP_READ, a, DPBR_DATA_ZERO, 1'b0, 1'b0);
        end
      join
      check(got_d, collide_word(skew_ok[1 - s], expect_word(a), ~d));
      model[a[DPBR_MEM_AW-1:0]] = ~d;
    end
    // one counter step into the unmasked maximum, then master reset while the wrap flag is low
    a = DPBR_MASK_RESET;
    issue(0, DPBR_OP_WRITE, a, d, 1'b0, 1'b0);
    model[a[DPBR_MEM_AW-1:0]] = d;
    issue(0, DPBR_OP_READ, a ^ 17'h00001, DPBR_DATA_ZERO, 1'b0, 1'b0);
    issue(0, DPBR_OP_NOP, a ^ 17'h00001, DPBR_DATA_ZERO, 1'b0, 1'b0);
    check(got_d, expect_word(a));
    reset_req[0] <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    check(g_side[0].pins.counter_wrap_irq_n, 1'b1);
    check({g_side[0].pins.data_dev_oe, g_side[0].pins.addr_dev_oe}, 2'b00);
    @(negedge clk);
    check(wrap_seen[0], 1'b1);
    @(posedge clk);
    reset_req[0] <= 1'b0;
    repeat (4) @(posedge clk);
    issue(0, DPBR_OP_READ, DPBR_ADDR_ZERO, DPBR_DATA_ZERO, 1'b1, 1'b1);
    check(got_a, DPBR_MASK_RESET);
    check(wrap_seen[0], 1'b0);
    final_report;
  end
endmodule
